// File: rtl/xbr_pkg.sv
// Purpose: Shared constants and types for the external bus background read engine
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Offsets are word aligned
package xbr_pkg;
    localparam int XBR_AW = 8;
    localparam logic [7:0] XBR_OFS_MODE = 8'h00;
    localparam logic [7:0] XBR_OFS_RIS = 8'h04;
    localparam logic [7:0] XBR_OFS_MIS = 8'h08;
    localparam logic [7:0] XBR_OFS_IEN = 8'h0c;
    localparam logic [7:0] XBR_OFS_ERR = 8'h10;
    localparam logic [7:0] XBR_OFS_FCFG = 8'h14;
    localparam logic [7:0] XBR_OFS_RXCNT = 8'h18;
    localparam logic [7:0] XBR_OFS_TXFREE = 8'h1c;
    localparam logic [7:0] XBR_OFS_RDATA = 8'h20;
    localparam logic [7:0] XBR_OFS_CH0_CFG = 8'h30;
    localparam logic [7:0] XBR_OFS_CH0_ADDR = 8'h34;
    localparam logic [7:0] XBR_OFS_CH0_CMD = 8'h38;
    localparam logic [7:0] XBR_OFS_CH0_REM = 8'h3c;
    localparam logic [7:0] XBR_CH_STRIDE = 8'h10;
    // Field positions
    localparam int XBR_INT_TXREQ = 0;
    localparam int XBR_INT_RXREQ = 1;
    localparam int XBR_INT_ERR = 2;
    localparam int XBR_ERR_WTFULL = 0;
    localparam int XBR_ERR_RSTALL = 1;
    localparam int XBR_ERR_TIMEOUT = 2;
    localparam int XBR_CMD_START = 31;
    localparam int XBR_CMD_STOP = 30;
    // Widths and depths
    localparam int XBR_CNT_W = 12;
    localparam int XBR_RXF_DEPTH = 8;
    localparam int XBR_RXF_PW = 3;
    localparam int XBR_TXF_DEPTH = 4;
    localparam logic [2:0] XBR_TXF_FREE_RST = 3'h4;
    // Reset values
    localparam logic [2:0] XBR_MODE_RST = 3'h0;
    localparam logic [3:0] XBR_FCFG_RST = 4'h2;
    typedef enum logic [2:0] {
        interface_off_mode = 3'h0,
        general_purpose_bus_mode = 3'h1,
        sync_dram_mode = 3'h2,
        host_bus_byte_mode = 3'h3,
        host_bus_halfword_mode = 3'h4
    } xbr_mode_type;
    typedef enum logic [1:0] {
        item_size_byte = 2'h0,
        item_size_halfword = 2'h1,
        item_size_word = 2'h2
    } xbr_size_type;
endpackage : xbr_pkg

// File: rtl/xbr_chan.sv
// Purpose: One background read channel: address, size and remaining count
// Assumes: Start and stop are one-cycle pulses from the register block
// Notes: Channel holds its address across transactions
`default_nettype none
module xbr_chan
    import xbr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cfg_we_i,
    input wire logic [1:0] cfg_size_i,
    input wire logic addr_we_i,
    input wire logic [31:0] addr_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [XBR_CNT_W-1:0] count_i,
    input wire logic fetched_i,
    output logic busy_o,
    output logic [1:0] size_o,
    output logic [31:0] addr_o,
    output logic [XBR_CNT_W-1:0] remain_o
);
    logic [1:0] size_q, size_d;
    logic [31:0] addr_q, addr_d;
    logic [XBR_CNT_W-1:0] rem_q, rem_d;
    logic [2:0] step;

    always_comb
    begin
        unique case (xbr_size_type'(size_q))
            item_size_halfword: step = 3'h2;
            item_size_word: step = 3'h4;
            default: step = 3'h1;
        endcase
    end

    always_comb
    begin
        size_d = size_q;
        addr_d = addr_q;
        rem_d = rem_q;
        if (cfg_we_i && cfg_size_i <= 2'h2)
        begin
            size_d = cfg_size_i;
        end
        if (addr_we_i)
        begin
            addr_d = addr_i;
        end
        if (fetched_i && rem_q != '0)
        begin
            addr_d = addr_q + 32'(step);
            rem_d = rem_q - 1'b1;
        end
        if (stop_i)
        begin
            rem_d = '0;
        end
        else if (start_i && count_i != '0 && rem_q == '0)
        begin
            rem_d = count_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            size_q <= 2'h2;
            addr_q <= 32'h0;
            rem_q <= '0;
        end
        else
        begin
            size_q <= size_d;
            addr_q <= addr_d;
            rem_q <= rem_d;
        end
    end

    assign busy_o = rem_q != '0;
    assign size_o = size_q;
    assign addr_o = addr_q;
    assign remain_o = rem_q;
endmodule // xbr_chan
`default_nettype wire

// File: rtl/xbr_top.sv
// Purpose: External bus interface mode, interrupt status and two-channel background read engine
// Assumes: Classic Wishbone slave at 250 MHz; external read port answers with ext_rvalid_i
// Notes: One read outstanding at a time; channel 0 has priority when both are busy
//
// What this block does
// - Exactly one usage mode is active: general, sync DRAM, byte host, halfword host, off.
// - Any mode but off enables the interface; off disables it.
// - Raw and masked interrupt status views are both readable.
// - Status holds write request, read request and summary error flags.
// - Each source has an enable; only enabled sources drive the interrupt line.
// - Two independent read channels, usable alone or together; channel 0 is served first until it finishes.
// - Each channel takes an item size of 8, 16 or 32 bits.
// - Channel start address is relative to the external device, origin zero.
// - Channel keeps its address so a new start continues sequentially.
// - Start command carries an item count from 1 to 4095.
// - After start the engine reads autonomously and pushes items into the read FIFO.
// - Reads pause while the read FIFO is full and resume when space frees.
// - A stop command cancels a channel's transaction in progress.
// - Each channel's remaining item count is readable.
// - The number of items held in the read FIFO is readable.
// - Each read of the FIFO data location pops one item at its width.
// - The number of empty write FIFO slots is readable.
// - Write request while below trigger; read request while above trigger.
// - Error flag from write-full, read stall or timeout, each readable and clearable.
`default_nettype none
module xbr_top
    import xbr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [XBR_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic ext_rreq_o,
    output logic [31:0] ext_raddr_o,
    output logic [1:0] ext_rsize_o,
    input wire logic ext_rvalid_i,
    input wire logic [31:0] ext_rdata_i,
    input wire logic [2:0] txf_used_i,
    input wire logic err_wtfull_i,
    input wire logic err_rstall_i,
    input wire logic err_timeout_i,
    output logic enable_o,
    output logic [2:0] mode_o,
    output logic irq_o
);
    logic [2:0] mode_q, mode_d;
    logic en_q, en_d;
    logic [2:0] ien_q, ien_d;
    logic [2:0] err_q, err_d;
    logic [3:0] fcfg_q, fcfg_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic irq_q, irq_d;
    logic rreq_q, rreq_d;
    logic [31:0] raddr_q, raddr_d;
    logic [1:0] rsize_q, rsize_d;
    logic own_q, own_d;
    logic [31:0] rxf_mem [XBR_RXF_DEPTH];
    logic [1:0] rxf_sz [XBR_RXF_DEPTH];
    logic [XBR_RXF_PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [XBR_RXF_PW:0] cnt_q, cnt_d;
    logic [2:0] wsync1_q, wsync2_q;
    logic [2:0] esync1_q, esync2_q;
    logic vsync1_q, vsync2_q;
    logic [31:0] dsync1_q, dsync2_q;
    logic acc, wr, rd, push, pop;
    logic [2:0] raw, tx_free;
    logic [1:0] cfg_we, addr_we, start, stop, fetched, busy;
    logic [1:0] ch_size [2];
    logic [31:0] ch_addr [2];
    logic [XBR_CNT_W-1:0] ch_rem [2];

    // Mask an item down to the width it was fetched at
    function automatic logic [31:0] size_mask(input logic [1:0] sz, input logic [31:0] d);
        unique case (xbr_size_type'(sz))
            item_size_byte: size_mask = {24'h0, d[7:0]};
            item_size_halfword: size_mask = {16'h0, d[15:0]};
            default: size_mask = d;
        endcase
    endfunction

    function automatic logic hit(input logic [XBR_AW-1:0] a, input logic [7:0] ofs);
        hit = a == ofs[XBR_AW-1:0];
    endfunction

    // External inputs come from the bus unit's own pin logic; resynchronised
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wsync1_q <= 3'h0;
            wsync2_q <= 3'h0;
            esync1_q <= 3'h0;
            esync2_q <= 3'h0;
            vsync1_q <= 1'b0;
            vsync2_q <= 1'b0;
            dsync1_q <= 32'h0;
            dsync2_q <= 32'h0;
        end
        else
        begin
            wsync1_q <= txf_used_i;
            wsync2_q <= wsync1_q;
            esync1_q <= {err_timeout_i, err_rstall_i, err_wtfull_i};
            esync2_q <= esync1_q;
            vsync1_q <= ext_rvalid_i;
            vsync2_q <= vsync1_q;
            dsync1_q <= ext_rdata_i;
            dsync2_q <= dsync1_q;
        end
    end

    assign acc = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign rd = acc && !wb_we_i;
    assign tx_free = XBR_TXF_FREE_RST - wsync2_q;
    assign pop = rd && hit(wb_adr_i, XBR_OFS_RDATA) && cnt_q != '0;
    assign push = rreq_q && vsync2_q;
    assign raw[XBR_INT_TXREQ] = {1'b0, wsync2_q} < ({2'h0, fcfg_q[1:0]} + 4'h0);
    assign raw[XBR_INT_RXREQ] = cnt_q > {1'b0, fcfg_q[3:2], 1'b0};
    assign raw[XBR_INT_ERR] = err_q != 3'h0;

    generate
        for (genvar c = 0; c < 2; c++)
        begin : g_ch
            localparam logic [7:0] BASE = XBR_OFS_CH0_CFG + 8'(c) * XBR_CH_STRIDE;
            assign cfg_we[c] = wr && hit(wb_adr_i, BASE);
            assign addr_we[c] = wr && hit(wb_adr_i, BASE + 8'h4);
            assign start[c] = wr && hit(wb_adr_i, BASE + 8'h8) && wb_dat_i[XBR_CMD_START];
            assign stop[c] = wr && hit(wb_adr_i, BASE + 8'h8) && wb_dat_i[XBR_CMD_STOP];
            assign fetched[c] = push && (own_q == 1'(c));
            xbr_chan u_chan (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .cfg_we_i(cfg_we[c]),
                .cfg_size_i(wb_dat_i[1:0]),
                .addr_we_i(addr_we[c]),
                .addr_i(wb_dat_i),
                .start_i(start[c]),
                .stop_i(stop[c]),
                .count_i(wb_dat_i[XBR_CNT_W-1:0]),
                .fetched_i(fetched[c]),
                .busy_o(busy[c]),
                .size_o(ch_size[c]),
                .addr_o(ch_addr[c]),
                .remain_o(ch_rem[c])
            );
        end
    endgenerate

    // Issue engine: one request outstanding; room is reserved before issuing
    // The resynchronised valid of the last answer must clear first, or it would push a stale item
    always_comb
    begin
        rreq_d = rreq_q;
        raddr_d = raddr_q;
        rsize_d = rsize_q;
        own_d = own_q;
        if (rreq_q && (vsync2_q || !busy[own_q]))
        begin
            rreq_d = 1'b0;
        end
        else if (!rreq_q && !vsync1_q && !vsync2_q && mode_q != XBR_MODE_RST
            && cnt_q < XBR_RXF_DEPTH[XBR_RXF_PW:0])
        begin
            if (busy[0] || busy[1])
            begin
                own_d = !busy[0];
                rreq_d = 1'b1;
                raddr_d = busy[0] ? ch_addr[0] : ch_addr[1];
                rsize_d = busy[0] ? ch_size[0] : ch_size[1];
            end
        end
    end

    always_comb
    begin
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push)
        begin
            wp_d = wp_q + 1'b1;
        end
        if (pop)
        begin
            rp_d = rp_q + 1'b1;
        end
        cnt_d = cnt_q + {{XBR_RXF_PW{1'b0}}, push} - {{XBR_RXF_PW{1'b0}}, pop};
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            rxf_mem[wp_q] <= size_mask(rsize_q, dsync2_q);
            rxf_sz[wp_q] <= rsize_q;
        end
    end

    always_comb
    begin
        mode_d = mode_q;
        ien_d = ien_q;
        fcfg_d = fcfg_q;
        err_d = err_q;
        ack_d = acc;
        dat_d = 32'h0;
        if (wr && hit(wb_adr_i, XBR_OFS_MODE) && wb_dat_i[2:0] <= 3'h4)
        begin
            mode_d = wb_dat_i[2:0];
        end
        en_d = mode_d != XBR_MODE_RST;
        if (wr && hit(wb_adr_i, XBR_OFS_IEN))
        begin
            ien_d = wb_dat_i[2:0];
        end
        if (wr && hit(wb_adr_i, XBR_OFS_FCFG))
        begin
            fcfg_d = wb_dat_i[3:0];
        end
        // Write one to clear; a new event in the same cycle wins
        if (wr && hit(wb_adr_i, XBR_OFS_ERR))
        begin
            err_d = err_q & ~wb_dat_i[2:0];
        end
        err_d = err_d | esync2_q;
        if (rd)
        begin
            if (hit(wb_adr_i, XBR_OFS_MODE))
                dat_d = {29'h0, mode_q};
            else if (hit(wb_adr_i, XBR_OFS_RIS))
                dat_d = {29'h0, raw};
            else if (hit(wb_adr_i, XBR_OFS_MIS))
                dat_d = {29'h0, raw & ien_q};
            else if (hit(wb_adr_i, XBR_OFS_IEN))
                dat_d = {29'h0, ien_q};
            else if (hit(wb_adr_i, XBR_OFS_ERR))
                dat_d = {29'h0, err_q};
            else if (hit(wb_adr_i, XBR_OFS_FCFG))
                dat_d = {28'h0, fcfg_q};
            else if (hit(wb_adr_i, XBR_OFS_RXCNT))
                dat_d = {28'h0, cnt_q};
            else if (hit(wb_adr_i, XBR_OFS_TXFREE))
                dat_d = {29'h0, tx_free};
            else if (hit(wb_adr_i, XBR_OFS_RDATA))
                dat_d = (cnt_q != '0) ? size_mask(rxf_sz[rp_q], rxf_mem[rp_q]) : 32'h0;
            else if (hit(wb_adr_i, XBR_OFS_CH0_CFG))
                dat_d = {30'h0, ch_size[0]};
            else if (hit(wb_adr_i, XBR_OFS_CH0_ADDR))
                dat_d = ch_addr[0];
            else if (hit(wb_adr_i, XBR_OFS_CH0_REM))
                dat_d = {20'h0, ch_rem[0]};
            else if (hit(wb_adr_i, XBR_OFS_CH0_CFG + XBR_CH_STRIDE))
                dat_d = {30'h0, ch_size[1]};
            else if (hit(wb_adr_i, XBR_OFS_CH0_ADDR + XBR_CH_STRIDE))
                dat_d = ch_addr[1];
            else if (hit(wb_adr_i, XBR_OFS_CH0_REM + XBR_CH_STRIDE))
                dat_d = {20'h0, ch_rem[1]};
        end
        irq_d = |(raw & ien_q);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= XBR_MODE_RST;
            en_q <= 1'b0;
            ien_q <= 3'h0;
            fcfg_q <= XBR_FCFG_RST;
            err_q <= 3'h0;
            ack_q <= 1'b0;
            dat_q <= 32'h0;
            irq_q <= 1'b0;
            rreq_q <= 1'b0;
            raddr_q <= 32'h0;
            rsize_q <= 2'h0;
            own_q <= 1'b0;
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            mode_q <= mode_d;
            en_q <= en_d;
            ien_q <= ien_d;
            fcfg_q <= fcfg_d;
            err_q <= err_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
            irq_q <= irq_d;
            rreq_q <= rreq_d;
            raddr_q <= raddr_d;
            rsize_q <= rsize_d;
            own_q <= own_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign ext_rreq_o = rreq_q;
    assign ext_raddr_o = raddr_q;
    assign ext_rsize_o = rsize_q;
    assign mode_o = mode_q;
    assign enable_o = en_q;
    assign irq_o = irq_q;
endmodule // xbr_top
`default_nettype wire

// File: bench/xbr_checker.sv
// Purpose: Port-level assertions for the background read engine
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the top module from the bench top file
`default_nettype none
module xbr_checker
    import xbr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic ext_rreq_o,
    input wire logic [31:0] ext_raddr_o,
    input wire logic [1:0] ext_rsize_o,
    input wire logic ext_rvalid_i,
    input wire logic enable_o,
    input wire logic [2:0] mode_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_after_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("register access not answered next cycle");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    enable_follows_mode_a: assert property (enable_o == (mode_o != 3'h0))
        else $error("enable does not match mode");
    mode_in_range_a: assert property (mode_o <= 3'h4)
        else $error("mode outside the five settings");
    request_when_on_a: assert property ($rose(ext_rreq_o) |-> $past(enable_o))
        else $error("read request while interface off");
    request_steady_a: assert property (ext_rreq_o && $past(ext_rreq_o) |-> $stable(ext_raddr_o) && $stable(ext_rsize_o))
        else $error("request qualifiers moved");
    request_retires_a: assert property (ext_rreq_o && ext_rvalid_i |-> ##[1:5] !ext_rreq_o)
        else $error("answered request not retired");
    size_legal_a: assert property (ext_rreq_o |-> ext_rsize_o <= 2'h2)
        else $error("illegal item size on request");

    cover property ($rose(ext_rreq_o));
    cover property (ext_rreq_o && ext_rvalid_i);
    cover property ($rose(irq_o));
    cover property (mode_o == 3'h4);
endmodule // xbr_checker
`default_nettype wire

// File: bench/xbr_ext_model.sv
// Purpose: Far-side device answering background reads
// Assumes: Engine holds a request until it takes the data
// Notes: Released data lines toggle each cycle so stale values never match
`default_nettype none
module xbr_ext_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rreq_i,
    input wire logic [31:0] raddr_i,
    input wire logic [1:0] rsize_i,
    input wire logic [3:0] delay_i,
    output logic rvalid_o,
    output logic [31:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    logic [31:0] pat_q;
    always_ff @(posedge clk_i)
    begin
        pat_q <= rst_i ? 32'h5a5a_0f0f : ~pat_q;
        if (rst_i || !rreq_i)
            cnt_q <= 4'h0;
        else if (cnt_q != 4'hf)
            cnt_q <= cnt_q + 4'h1;
    end
    // Valid falls with the request, so an old answer never meets the next one
    assign rvalid_o = rreq_i && (cnt_q > delay_i);
    // Narrow items sit in every lane, so any lane choice finds them
    assign rdata_o = !rvalid_o ? pat_q : rsize_i == 2'h0 ? {4{raddr_i[7:0]}} :
        rsize_i == 2'h1 ? {2{raddr_i[15:0]}} : {~raddr_i[15:0], raddr_i[15:0]};
endmodule // xbr_ext_model
`default_nettype wire

// File: bench/xbr_top_test.sv
// Purpose: Self-checking bench for the background read engine
// Assumes: Ack comes one cycle after the taken edge
// Notes: Device data is derived from its address
`default_nettype none
module xbr_top_test
    import xbr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, raddr, rdata;
    logic ack, rreq, rvalid, en, irq;
    logic [1:0] rsize;
    logic [2:0] mode, txf_used = 3'h0, errs = 3'h0;
    logic [3:0] delay = 4'h0;
    int fail_count = 0, tests_run = 0, cycles = 0;

    xbr_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_rreq_o(rreq), .ext_raddr_o(raddr), .ext_rsize_o(rsize), .ext_rvalid_i(rvalid),
        .ext_rdata_i(rdata), .txf_used_i(txf_used), .err_wtfull_i(errs[0]), .err_rstall_i(errs[1]),
        .err_timeout_i(errs[2]), .enable_o(en), .mode_o(mode), .irq_o(irq));
    xbr_ext_model dev (.clk_i(clk_i), .rst_i(rst_i), .rreq_i(rreq), .raddr_i(raddr), .rsize_i(rsize),
        .delay_i(delay), .rvalid_o(rvalid), .rdata_o(rdata));

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    function automatic logic [31:0] item(input logic [31:0] a);
        return {~a[15:0], a[15:0]};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Request held until ack is sampled; released for one idle cycle after
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic poll(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        repeat (400) if (q !== e) wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic test_reset;
        chk(en, 32'h0);
        rdc(XBR_OFS_MODE, 32'h0);
        rdc(XBR_OFS_TXFREE, 32'h4);
        rdc(XBR_OFS_RXCNT, 32'h0);
        rdc(XBR_OFS_RIS, 32'h1);
        rdc(8'hfc, 32'h0);
        $display("reset test done");
    endtask

    task automatic test_mode;
        for (int m = 0; m < 5; m++)
        begin
            wr(XBR_OFS_MODE, 32'(m));
            rdc(XBR_OFS_MODE, 32'(m));
            chk(en, 32'(m != 0));
        end
        wr(XBR_OFS_MODE, 32'h5);
        rdc(XBR_OFS_MODE, 32'h4);
        wr(XBR_OFS_MODE, 32'(general_purpose_bus_mode));
        $display("mode test done");
    endtask

    task automatic test_stream;
        wr(XBR_OFS_CH0_CFG, 32'(item_size_word));
        wr(XBR_OFS_CH0_ADDR, 32'h100);
        wr(XBR_OFS_CH0_CMD, 32'h8000_0000);
        rdc(XBR_OFS_CH0_REM, 32'h0);
        wr(XBR_OFS_CH0_CMD, 32'h8000_0003);
        poll(XBR_OFS_RXCNT, 32'h3);
        rdc(XBR_OFS_CH0_REM, 32'h0);
        for (int k = 0; k < 3; k++)
            rdc(XBR_OFS_RDATA, item(32'h100 + 32'(4 * k)));
        rdc(XBR_OFS_RDATA, 32'h0);
        rdc(XBR_OFS_RXCNT, 32'h0);
        wr(XBR_OFS_CH0_CMD, 32'h8000_0001);
        poll(XBR_OFS_RXCNT, 32'h1);
        rdc(XBR_OFS_RDATA, item(32'h10c));
        $display("stream test done");
    endtask

    task automatic test_full;
        logic [31:0] q;
        wr(XBR_OFS_CH0_CFG + XBR_CH_STRIDE, 32'(item_size_byte));
        wr(XBR_OFS_CH0_ADDR + XBR_CH_STRIDE, 32'h0);
        wr(XBR_OFS_CH0_CMD + XBR_CH_STRIDE, 32'h8000_000a);
        poll(XBR_OFS_RXCNT, 32'h8);
        repeat (20) @(posedge clk_i);
        rdc(XBR_OFS_CH0_REM + XBR_CH_STRIDE, 32'h2);
        for (int k = 0; k < 10; k++)
        begin
            if (k == 8)
                poll(XBR_OFS_RXCNT, 32'h2);
            wb(1'b0, XBR_OFS_RDATA, 32'h0, q);
            chk(q & 32'hff, 32'(k));
        end
        $display("full test done");
    endtask

    task automatic test_stop;
        logic [31:0] n, q;
        delay <= 4'ha;
        wr(XBR_OFS_CH0_CMD, 32'h8000_0014);
        poll(XBR_OFS_RXCNT, 32'h2);
        wr(XBR_OFS_CH0_CMD, 32'h4000_0000);
        repeat (40) @(posedge clk_i);
        wb(1'b0, XBR_OFS_RXCNT, 32'h0, n);
        repeat (60) @(posedge clk_i);
        chk(rreq, 32'h0);
        rdc(XBR_OFS_RXCNT, n);
        repeat (n) wb(1'b0, XBR_OFS_RDATA, 32'h0, q);
        rdc(XBR_OFS_RXCNT, 32'h0);
        delay <= 4'h0;
        $display("stop test done");
    endtask

    task automatic test_irq;
        txf_used <= 3'h3;
        for (int b = 0; b < 3; b++)
        begin
            if (b == 1)
                wr(XBR_OFS_IEN, 32'h4);
            errs <= 3'(1 << b);
            repeat (4) @(posedge clk_i);
            errs <= 3'h0;
            rdc(XBR_OFS_ERR, 32'(1 << b));
            rdc(XBR_OFS_RIS, 32'h4);
            rdc(XBR_OFS_MIS, 32'(b != 0) << 2);
            chk(irq, 32'(b != 0));
            wr(XBR_OFS_ERR, 32'(1 << b));
            rdc(XBR_OFS_ERR, 32'h0);
        end
        chk(irq, 32'h0);
        rdc(XBR_OFS_TXFREE, 32'h1);
        wr(XBR_OFS_FCFG, 32'h6);
        wr(XBR_OFS_CH0_ADDR, 32'h200);
        wr(XBR_OFS_CH0_CMD, 32'h8000_0003);
        poll(XBR_OFS_RXCNT, 32'h3);
        rdc(XBR_OFS_RIS, 32'h2);
        rdc(XBR_OFS_RDATA, item(32'h200));
        rdc(XBR_OFS_RIS, 32'h0);
        $display("interrupt test done");
    endtask

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_reset();
        test_mode();
        test_stream();
        test_full();
        test_stop();
        test_irq();
        print_verdict();
    end
endmodule // xbr_top_test

bind xbr_top xbr_checker chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .ext_rreq_o(ext_rreq_o), .ext_raddr_o(ext_raddr_o), .ext_rsize_o(ext_rsize_o),
    .ext_rvalid_i(ext_rvalid_i), .enable_o(enable_o), .mode_o(mode_o), .irq_o(irq_o));
`default_nettype wire
